/* File: verilog/ddsc_defines.vh */
// Constants for the dual DAC serial control block
`ifndef DDSC_DEFINES_VH
`define DDSC_DEFINES_VH

// Word layout
`define DDSC_WORD_BITS 16
`define DDSC_CODE_BITS 12
`define DDSC_CMD_MSB 15
`define DDSC_CMD_LSB 12
`define DDSC_CODE_MSB 11
`define DDSC_CODE_LSB 0
`define DDSC_CNT_BITS 5
`define DDSC_CNT_FULL 5'h10
`define DDSC_CNT_STEP 5'h01

// Commands
`define DDSC_CMD_NOP 4'h0
`define DDSC_CMD_LOAD_ALL 4'h1
`define DDSC_CMD_IN_A 4'h2
`define DDSC_CMD_IN_B 4'h3
`define DDSC_CMD_BOTH_A 4'h4
`define DDSC_CMD_BOTH_B 4'h5
`define DDSC_CMD_UPD_A 4'h6
`define DDSC_CMD_UPD_B 4'h7
`define DDSC_CMD_POWER_DOWN_N_A 4'h8
`define DDSC_CMD_POWER_DOWN_N_B 4'h9
`define DDSC_CMD_UPD_AB 4'ha
`define DDSC_CMD_POWER_DOWN_N_AB 4'hb
`define DDSC_CMD_PUP_A 4'hc
`define DDSC_CMD_PUP_B 4'hd
`define DDSC_CMD_PUP_AB 4'he
`define DDSC_CMD_UNUSED 4'hf

// Reset values
`define DDSC_CODE_RESET 12'h000
`define DDSC_WORD_RESET 16'h0000

`endif

/* File: verilog/ddsc_control.v */
// Dual DAC serial control logic: link, registers, load, clear, shutdown
`include "ddsc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module ddsc_control #(
   parameter CODE_W = `DDSC_CODE_BITS,
   parameter WORD_W = `DDSC_WORD_BITS
) (
   // Clock and reset
   input wire mclk,
   input wire arst_n,
   // Serial link pins
   input wire serialClk,
   input wire chipSelect_n,
   input wire serialIn,
   output reg serialOut,
   output reg serialOutEn,
   // Control pins
   input wire load_outputs_n,
   input wire clear_outputs_n,
   input wire power_down_n,
   input wire range_select_a,
   input wire range_select_b,
   // Channel A output stage
   output reg [CODE_W-1:0] dacCodeA,
   output reg channelOnA,
   output reg unipolarA,
   // Channel B output stage
   output reg [CODE_W-1:0] dacCodeB,
   output reg channelOnB,
   output reg unipolarB
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   reg [6:0] syncMeta;
   reg [6:0] syncPins;
   wire [6:0] rawPins;
   assign rawPins = {range_select_b, range_select_a, power_down_n,
                     clear_outputs_n, load_outputs_n, chipSelect_n, serialClk};

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         syncMeta <= 7'h1e;
         syncPins <= 7'h1e;
      end else begin
         syncMeta <= rawPins;
         syncPins <= syncMeta;
      end
   end

   wire sclkS;
   wire csS_n;
   wire loadS_n;
   wire clearS_n;
   wire pdS_n;
   wire rangeAS;
   wire rangeBS;
   assign sclkS = syncPins[0];
   assign csS_n = syncPins[1];
   assign loadS_n = syncPins[2];
   assign clearS_n = syncPins[3];
   assign pdS_n = syncPins[4];
   assign rangeAS = syncPins[5];
   assign rangeBS = syncPins[6];

   // ****************************************
   // Edge detection
   // ****************************************
   reg sclkPrev;
   reg csPrev_n;
   reg loadPrev_n;

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sclkPrev <= 1'b0;
         csPrev_n <= 1'b1;
         loadPrev_n <= 1'b1;
      end else begin
         sclkPrev <= sclkS;
         csPrev_n <= csS_n;
         loadPrev_n <= loadS_n;
      end
   end

   wire sclkRise;
   wire sclkFall;
   wire csFall;
   wire csRise;
   wire loadFall;
   assign sclkRise = sclkS & ~sclkPrev;
   assign sclkFall = ~sclkS & sclkPrev;
   assign csFall = ~csS_n & csPrev_n;
   assign csRise = csS_n & ~csPrev_n;
   assign loadFall = ~loadS_n & loadPrev_n;

   // ****************************************
   // Shift register and bit count
   // ****************************************
   reg [WORD_W-1:0] shiftWord;
   reg [`DDSC_CNT_BITS-1:0] bitCount;
   reg wordSpoiled;
   reg dinMeta;
   reg serialInS;

   // Data pin sampled through the same two-stage chain
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dinMeta <= 1'b0;
         serialInS <= 1'b0;
      end else begin
         dinMeta <= serialIn;
         serialInS <= dinMeta;
      end
   end

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         shiftWord <= `DDSC_WORD_RESET;
         bitCount <= {`DDSC_CNT_BITS{1'b0}};
      end else if (csFall) begin
         bitCount <= {`DDSC_CNT_BITS{1'b0}};
      end else if (!csS_n && sclkRise) begin
         shiftWord <= {shiftWord[WORD_W-2:0], serialInS};
         if (bitCount != `DDSC_CNT_FULL) begin
            bitCount <= bitCount + `DDSC_CNT_STEP;
         end
      end
   end

   // Load or clear while selected spoils the word; spoiling wins over select fall
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wordSpoiled <= 1'b0;
      end else if (!csS_n && (loadFall || !clearS_n)) begin
         wordSpoiled <= 1'b1;
      end else if (csFall) begin
         wordSpoiled <= 1'b0;
      end
   end

   // ****************************************
   // Serial output for chaining
   // ****************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         serialOut <= 1'b0;
         serialOutEn <= 1'b0;
      end else begin
         serialOutEn <= ~csS_n & pdS_n;
         if (!csS_n && sclkFall) begin
            serialOut <= shiftWord[WORD_W-1];
         end
      end
   end

   // ****************************************
   // Command decode
   // ****************************************
   wire wordDone;
   wire [3:0] cmd;
   wire [CODE_W-1:0] code;
   assign wordDone = csRise & (bitCount == `DDSC_CNT_FULL) & ~wordSpoiled;
   assign cmd = shiftWord[`DDSC_CMD_MSB:`DDSC_CMD_LSB];
   assign code = shiftWord[`DDSC_CODE_MSB:`DDSC_CODE_LSB];

   // ****************************************
   // Input, DAC and power registers
   // ****************************************
   reg [CODE_W-1:0] inRegA;
   reg [CODE_W-1:0] inRegB;
   reg [CODE_W-1:0] next_inRegA;
   reg [CODE_W-1:0] next_inRegB;
   reg [CODE_W-1:0] next_dacA;
   reg [CODE_W-1:0] next_dacB;
   reg softOffA;
   reg softOffB;
   reg next_softOffA;
   reg next_softOffB;

   always @* begin
      next_inRegA = inRegA;
      next_inRegB = inRegB;
      next_dacA = dacCodeA;
      next_dacB = dacCodeB;
      next_softOffA = softOffA;
      next_softOffB = softOffB;
      if (wordDone) begin
         case (cmd)
            `DDSC_CMD_LOAD_ALL: begin
               next_inRegA = code;
               next_inRegB = code;
               next_dacA = code;
               next_dacB = code;
            end
            `DDSC_CMD_IN_A: begin
               next_inRegA = code;
            end
            `DDSC_CMD_IN_B: begin
               next_inRegB = code;
            end
            `DDSC_CMD_BOTH_A: begin
               next_inRegA = code;
               next_dacA = code;
            end
            `DDSC_CMD_BOTH_B: begin
               next_inRegB = code;
               next_dacB = code;
            end
            `DDSC_CMD_UPD_A: begin
               next_dacA = inRegA;
            end
            `DDSC_CMD_UPD_B: begin
               next_dacB = inRegB;
            end
            `DDSC_CMD_UPD_AB: begin
               next_dacA = inRegA;
               next_dacB = inRegB;
            end
            `DDSC_CMD_POWER_DOWN_N_A: begin
               next_softOffA = softOffA | pdS_n;
            end
            `DDSC_CMD_POWER_DOWN_N_B: begin
               next_softOffB = softOffB | pdS_n;
            end
            `DDSC_CMD_POWER_DOWN_N_AB: begin
               next_softOffA = softOffA | pdS_n;
               next_softOffB = softOffB | pdS_n;
            end
            `DDSC_CMD_PUP_A: begin
               next_softOffA = 1'b0;
            end
            `DDSC_CMD_PUP_B: begin
               next_softOffB = 1'b0;
            end
            `DDSC_CMD_PUP_AB: begin
               next_softOffA = 1'b0;
               next_softOffB = 1'b0;
            end
            default: begin
               next_inRegA = inRegA;
            end
         endcase
      end
      if (loadFall) begin
         next_dacA = next_inRegA;
         next_dacB = next_inRegB;
      end
      if (!clearS_n) begin
         next_inRegA = `DDSC_CODE_RESET;
         next_inRegB = `DDSC_CODE_RESET;
         next_dacA = `DDSC_CODE_RESET;
         next_dacB = `DDSC_CODE_RESET;
      end
   end

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         inRegA <= `DDSC_CODE_RESET;
         inRegB <= `DDSC_CODE_RESET;
         dacCodeA <= `DDSC_CODE_RESET;
         dacCodeB <= `DDSC_CODE_RESET;
         softOffA <= 1'b0;
         softOffB <= 1'b0;
      end else begin
         inRegA <= next_inRegA;
         inRegB <= next_inRegB;
         dacCodeA <= next_dacA;
         dacCodeB <= next_dacB;
         softOffA <= next_softOffA;
         softOffB <= next_softOffB;
      end
   end

   // ****************************************
   // Output stage control
   // ****************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         channelOnA <= 1'b0;
         channelOnB <= 1'b0;
         unipolarA <= 1'b0;
         unipolarB <= 1'b0;
      end else begin
         channelOnA <= pdS_n & ~next_softOffA;
         channelOnB <= pdS_n & ~next_softOffB;
         unipolarA <= rangeAS;
         unipolarB <= rangeBS;
      end
   end

endmodule // ddsc_control

`default_nettype wire

/* File: testbench/ddsc_control_props.sv */
// Checker for the dual DAC serial control ports
`timescale 1ns/1ps
`default_nettype none
module ddsc_control_props (
   // Clock and reset
   input wire mclk,
   input wire arst_n,
   // Pins
   input wire chipSelect_n,
   input wire load_outputs_n,
   input wire clear_outputs_n,
   input wire power_down_n,
   input wire range_select_a,
   input wire range_select_b,
   input wire serialOutEn,
   // Channel state
   input wire [11:0] dacCodeA,
   input wire [11:0] dacCodeB,
   input wire channelOnA,
   input wire channelOnB,
   input wire unipolarA,
   input wire unipolarB
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence s_idle; chipSelect_n [*5]; endsequence
   sequence s_clr; !clear_outputs_n [*5]; endsequence
   sequence s_off; !power_down_n [*5]; endsequence
   sequence s_calm; (!chipSelect_n && load_outputs_n && clear_outputs_n) [*8]; endsequence
   property p_doutIdle; s_idle |-> !serialOutEn; endproperty
   property p_clrA; s_clr |-> dacCodeA == 12'h000; endproperty
   property p_clrB; s_clr |-> dacCodeB == 12'h000; endproperty
   property p_hwOff; s_off |-> !channelOnA && !channelOnB; endproperty
   property p_offDout; s_off |-> !serialOutEn; endproperty
   property p_rngA; $stable(range_select_a) [*4] |-> unipolarA == range_select_a; endproperty
   property p_rngB; $stable(range_select_b) [*4] |-> unipolarB == range_select_b; endproperty
   property p_calm; s_calm |-> $stable(dacCodeA) && $stable(dacCodeB); endproperty
   a_doutIdle: assert property (p_doutIdle) else $error("output driven while deselected");
   a_clrA: assert property (p_clrA) else $error("channel A code not cleared");
   a_clrB: assert property (p_clrB) else $error("channel B code not cleared");
   a_hwOff: assert property (p_hwOff) else $error("channel on in power down");
   a_offDout: assert property (p_offDout) else $error("output driven in power down");
   a_rngA: assert property (p_rngA) else $error("range A not followed");
   a_rngB: assert property (p_rngB) else $error("range B not followed");
   a_calm: assert property (p_calm) else $error("code moved without cause");
endmodule // ddsc_control_props
bind ddsc_control ddsc_control_props chk (.mclk(mclk), .arst_n(arst_n),
   .chipSelect_n(chipSelect_n), .load_outputs_n(load_outputs_n),
   .clear_outputs_n(clear_outputs_n), .power_down_n(power_down_n),
   .range_select_a(range_select_a), .range_select_b(range_select_b),
   .serialOutEn(serialOutEn), .dacCodeA(dacCodeA), .dacCodeB(dacCodeB),
   .channelOnA(channelOnA), .channelOnB(channelOnB), .unipolarA(unipolarA),
   .unipolarB(unipolarB));
`default_nettype wire

/* File: testbench/ddsc_host_model.sv */
// Host side serial link driver for the dual DAC control
`timescale 1ns/1ps
`default_nettype none
module ddsc_host_model (
   // Clock
   input wire logic mclk,
   // Link
   output logic serialClk,
   output logic chipSelect_n,
   output logic serialIn,
   input wire logic serialOut,
   // Bits seen on the chained output
   output logic [31:0] seenOut
);
   initial begin
      serialClk = 1'b0;
      chipSelect_n = 1'b1;
      serialIn = 1'b0;
      seenOut = 32'h0;
   end
   task automatic gap(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Send n bits, half period 16 ns
   task automatic xfer(input logic [31:0] bits, input int n);
      chipSelect_n <= 1'b0;
      gap(4);
      for (int i = n - 1; i >= 0; i--) begin
         serialIn <= bits[i];
         gap(4);
         seenOut <= {seenOut[30:0], serialOut};
         serialClk <= 1'b1;
         gap(4);
         serialClk <= 1'b0;
      end
      gap(4);
      chipSelect_n <= 1'b1;
      serialIn <= ~bits[0];
      gap(30);
   endtask
endmodule // ddsc_host_model
`default_nettype wire

/* File: testbench/dual_dac_serial_control_test.sv */
// Self-checking bench for the dual DAC serial control
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_control_test;
   logic mclk, arst_n, load_outputs_n, clear_outputs_n, power_down_n;
   logic range_select_a, range_select_b, swA, swB;
   logic [11:0] inA, inB, dA, dB;
   wire serialClk, chipSelect_n, serialIn, serialOut, serialOutEn;
   wire channelOnA, channelOnB, unipolarA, unipolarB;
   wire [11:0] dacCodeA, dacCodeB;
   wire [31:0] seenOut;
   int failures, samples_checked, cycles, seed;
   ddsc_control uut (.mclk(mclk), .arst_n(arst_n), .serialClk(serialClk),
      .chipSelect_n(chipSelect_n), .serialIn(serialIn), .serialOut(serialOut),
      .serialOutEn(serialOutEn), .load_outputs_n(load_outputs_n),
      .clear_outputs_n(clear_outputs_n), .power_down_n(power_down_n),
      .range_select_a(range_select_a), .range_select_b(range_select_b),
      .dacCodeA(dacCodeA), .channelOnA(channelOnA), .unipolarA(unipolarA),
      .dacCodeB(dacCodeB), .channelOnB(channelOnB), .unipolarB(unipolarB));
   // Undriven data out line shows the inverse of the last bit
   ddsc_host_model host (.mclk(mclk), .serialClk(serialClk), .chipSelect_n(chipSelect_n),
      .serialIn(serialIn), .serialOut(serialOutEn ? serialOut : ~serialOut),
      .seenOut(seenOut));
   task tally_and_finish;
      $display("checks=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task cmpAll;
      check(16'(dacCodeA), 16'(dA));
      check(16'(dacCodeB), 16'(dB));
      check(16'(channelOnA), 16'(swA & power_down_n));
      check(16'(channelOnB), 16'(swB & power_down_n));
      check(16'(unipolarA), 16'(range_select_a));
      check(16'(unipolarB), 16'(range_select_b));
   endtask
   // Reference model of one executed word
   task apply(input logic [15:0] w);
      logic [11:0] c;
      c = w[11:0];
      case (w[15:12])
         4'h1: begin inA = c; inB = c; dA = c; dB = c; end
         4'h2: inA = c;
         4'h3: inB = c;
         4'h4: begin inA = c; dA = c; end
         4'h5: begin inB = c; dB = c; end
         4'h6: dA = inA;
         4'h7: dB = inB;
         4'ha: begin dA = inA; dB = inB; end
         4'h8: if (power_down_n) swA = 1'b0;
         4'h9: if (power_down_n) swB = 1'b0;
         4'hb: if (power_down_n) begin swA = 1'b0; swB = 1'b0; end
         4'hc: swA = 1'b1;
         4'hd: swB = 1'b1;
         4'he: begin swA = 1'b1; swB = 1'b1; end
         default: ;
      endcase
   endtask
   task send(input logic [15:0] w);
      host.xfer({16'h0, w}, 16);
      apply(w);
      cmpAll();
   endtask
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   initial begin
      {arst_n, range_select_a, range_select_b} = 3'h0;
      {load_outputs_n, clear_outputs_n, power_down_n, swA, swB} = 5'h1f;
      {inA, inB, dA, dB} = 48'h0;
      seed = $urandom(40);
      host.gap(10);
      arst_n <= 1'b1;
      host.gap(6);
      cmpAll();
      for (int k = 0; k < 32; k++) begin
         range_select_a <= 1'($urandom);
         range_select_b <= 1'($urandom);
         power_down_n <= 1'($urandom);
         if ($urandom % 4 == 0) begin
            load_outputs_n <= 1'b0;
            host.gap(13);
            load_outputs_n <= 1'b1;
            dA = inA;
            dB = inB;
         end
         send({k[3:0], 12'($urandom)});
      end
      power_down_n <= 1'b1;
      send(16'h1fff);
      send(16'h4800);
      send(16'h5000);
      host.xfer(32'h2abc_3123, 32);
      apply(16'h3123);
      cmpAll();
      check(seenOut[15:0], 16'h2abc);
      host.xfer(32'h1555, 10);
      cmpAll();
      send(16'h2123);
      send(16'h3456);
      load_outputs_n <= 1'b0;
      host.gap(6);
      load_outputs_n <= 1'b1;
      host.gap(8);
      dA = inA;
      dB = inB;
      cmpAll();
      send(16'h2abc);
      fork
         host.xfer({16'h0, 16'h2fff}, 16);
         begin
            host.gap(40);
            load_outputs_n <= 1'b0;
            host.gap(13);
            load_outputs_n <= 1'b1;
         end
      join
      dA = inA;
      dB = inB;
      cmpAll();
      send(16'h6000);
      send(16'h2fff);
      send(16'h6000);
      power_down_n <= 1'b0;
      host.gap(8);
      send(16'hb000);
      send(16'h1777);
      power_down_n <= 1'b1;
      host.gap(8);
      cmpAll();
      clear_outputs_n <= 1'b0;
      host.gap(8);
      clear_outputs_n <= 1'b1;
      host.gap(8);
      {inA, inB, dA, dB} = 48'h0;
      cmpAll();
      send(16'ha000);
      tally_and_finish();
   end
endmodule // dual_dac_serial_control_test
`default_nettype wire
